// ===== ecs_pkg.sv
// Constants and types for the host command/status register pair.
// Assumes a single 40 MHz core clock and a plain register port.
//
// What this block does
// - A write to the command register at 8Ch starts the selected commands.
// - Writing one then zero to command bit 7 resets controller state, not ports.
// - Command bits 3 to 2 set the frame list length; reset value 00b.
// - Command bit 1 starts a full reset and clears itself when done.
// - The schedule runs while command bit 0 is one, stops when zero.
// - Status flags at 90h clear where software writes a one at 90h or F0h, and on a full or light reset.
// - Status shows only pending interrupt causes, never transaction outcomes.
// - Status bit 3 sets when the frame list index wraps to zero.
// - Status bit 2 sets on an owned port change or resume force rise.
// - Interrupt is high while rollover enable and rollover flag are both one.
// - Interrupt is high while port change enable and flag are both one.
package ecs_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ECS_CMD_OFS = 8'h8C;
  localparam logic [7:0] ECS_STS_OFS = 8'h90;
  localparam logic [7:0] ECS_IEN_OFS = 8'h94;
  localparam logic [7:0] ECS_CLR_OFS = 8'hF0;
  // ==========================================================
  // field positions and reset values
  localparam int unsigned ECS_RUN_BIT   = 0;
  localparam int unsigned ECS_FRST_BIT  = 1;
  localparam int unsigned ECS_FLS_LSB   = 2;
  localparam int unsigned ECS_LRST_BIT  = 7;
  localparam int unsigned ECS_PCD_BIT   = 2;
  localparam int unsigned ECS_FLR_BIT   = 3;
  localparam logic [31:0] ECS_CMD_RST   = 32'h0000_0000;
  localparam logic [31:0] ECS_STS_RST   = 32'h0000_0000;
  // ==========================================================
  // frame list size codes and lengths
  localparam logic [1:0]  ECS_FLS_1024  = 2'h0;
  localparam logic [1:0]  ECS_FLS_512   = 2'h1;
  localparam logic [1:0]  ECS_FLS_256   = 2'h2;
  localparam logic [10:0] ECS_LEN_1024  = 11'h400;
  localparam logic [10:0] ECS_LEN_512   = 11'h200;
  localparam logic [10:0] ECS_LEN_256   = 11'h100;
  // ==========================================================
  // full reset duration
  localparam int unsigned ECS_CLK_NS      = 25;
  localparam int unsigned ECS_FRST_NS     = 400;
  localparam int unsigned ECS_FRST_CYC    = (ECS_FRST_NS + ECS_CLK_NS - 1) / ECS_CLK_NS;
  localparam logic [4:0]  ECS_FRST_CNT    = 5'(ECS_FRST_CYC - 1);
  // ==========================================================
  // types
  typedef struct packed {
    logic       lightReset;
    logic [2:0] rsvd;
    logic [1:0] frame_list_size;
    logic       fullReset;
    logic       runStop;
  } ecs_cmd_type;

  typedef struct packed {
    logic frame_list_rollover;
    logic port_change_detected;
  } ecs_evt_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FULL = 2'b01,
    ST_DONE = 2'b11
  } ecs_state_type;
endpackage : ecs_pkg

// ===== ecs_cmd_status.sv
// Command/status register pair with interrupt gating and reset sequencing.
// Assumes frame index and port flags come from logic on core_clk.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module ecs_cmd_status #(
  parameter int unsigned PORT_COUNT = 1,
  parameter int unsigned CHG_BITS   = 3
) (
  input  wire logic                           core_clk,
  input  wire logic                           rst_n,
  input  wire logic [7:0]                     regAddr,
  input  wire logic [31:0]                    regWrData,
  input  wire logic                           regWrEn,
  input  wire logic                           regRdEn,
  output logic [31:0]                         regRdData,
  input  wire logic [13:0]                    frameIndex,
  input  wire logic [PORT_COUNT*CHG_BITS-1:0] portChangeBits,
  input  wire logic [PORT_COUNT-1:0]          ownerRelease,
  input  wire logic [PORT_COUNT-1:0]          resumeForce,
  output logic                                runSchedule,
  output logic [1:0]                          frameListSize,
  output logic [10:0]                         frameListEntries,
  output logic                                hostResetActive,
  output logic                                lightResetPulse,
  output logic                                hostIrq
);
  // ==========================================================
  // state
  ecs_pkg::ecs_cmd_type   cmdQ;
  ecs_pkg::ecs_evt_type   stsQ;
  ecs_pkg::ecs_evt_type   ienQ;
  ecs_pkg::ecs_state_type stateQ;
  logic [4:0]             rstCntQ;
  logic [13:0]            frameIdxQ;
  logic                   wrapBitPrev;
  logic                   lightQ;
  logic [31:0]            rdDataQ;
  logic                   rdValidQ;
  logic [PORT_COUNT-1:0]  portRise;
  logic                   wrapBit;
  logic                   wrCmd;
  logic                   wrSts;
  logic                   wrIen;
  logic                   wrClr;
  logic                   lightFall;
  logic                   busy;
  ecs_pkg::ecs_cmd_type   wrCmdVal;
  ecs_pkg::ecs_evt_type   setEvt;
  ecs_pkg::ecs_evt_type   clrEvt;
  ecs_pkg::ecs_evt_type   wrEvt;

  // ==========================================================
  // write decode
  assign busy     = (stateQ != ecs_pkg::ST_IDLE);
  assign wrCmd    = regWrEn && !busy && (regAddr == ecs_pkg::ECS_CMD_OFS);
  assign wrSts    = regWrEn && !busy && (regAddr == ecs_pkg::ECS_STS_OFS);
  assign wrIen    = regWrEn && !busy && (regAddr == ecs_pkg::ECS_IEN_OFS);
  assign wrClr    = regWrEn && !busy && (regAddr == ecs_pkg::ECS_CLR_OFS);
  assign wrCmdVal = ecs_pkg::ecs_cmd_type'(regWrData[7:0]);
  assign wrEvt.frame_list_rollover = regWrData[ecs_pkg::ECS_FLR_BIT];
  assign wrEvt.port_change_detected = regWrData[ecs_pkg::ECS_PCD_BIT];
  assign lightFall = wrCmd && cmdQ.lightReset && !wrCmdVal.lightReset;

  // ==========================================================
  // frame list wrap
  // watch bit above index
  always_comb begin
    unique case (cmdQ.frame_list_size)
      ecs_pkg::ECS_FLS_512: begin
        wrapBit     = frameIndex[12];
        wrapBitPrev = frameIdxQ[12];
      end
      ecs_pkg::ECS_FLS_256: begin
        wrapBit     = frameIndex[11];
        wrapBitPrev = frameIdxQ[11];
      end
      default: begin
        wrapBit     = frameIndex[13];
        wrapBitPrev = frameIdxQ[13];
      end
    endcase
  end

  // previous index, so a size change never fakes a wrap
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      frameIdxQ <= 14'h0000;
    end else begin
      frameIdxQ <= frameIndex;
    end
  end

  // ==========================================================
  // port change edges
  genvar gp;
  generate
    for (gp = 0; gp < PORT_COUNT; gp++) begin : g_port
      logic [CHG_BITS-1:0] chgPrevQ;
      logic                resPrevQ;
      logic [CHG_BITS-1:0] chgNow;
      assign chgNow = portChangeBits[gp*CHG_BITS +: CHG_BITS];
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          chgPrevQ <= '0;
          resPrevQ <= 1'b0;
        end else begin
          chgPrevQ <= chgNow;
          resPrevQ <= resumeForce[gp];
        end
      end
      assign portRise[gp] = !ownerRelease[gp]
                            && ((|(chgNow & ~chgPrevQ)) || (resumeForce[gp] && !resPrevQ));
    end
  endgenerate

  assign setEvt.frame_list_rollover = (wrapBit != wrapBitPrev);
  assign setEvt.port_change_detected = |portRise;
  assign clrEvt.frame_list_rollover = (wrSts || wrClr) && wrEvt.frame_list_rollover;
  assign clrEvt.port_change_detected = (wrSts || wrClr) && wrEvt.port_change_detected;

  // ==========================================================
  // reset sequencer
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stateQ  <= ecs_pkg::ST_IDLE;
      rstCntQ <= '0;
    end else begin
      unique case (stateQ)
        ecs_pkg::ST_IDLE: begin
          if (wrCmd && wrCmdVal.fullReset) begin
            stateQ  <= ecs_pkg::ST_FULL;
            rstCntQ <= ecs_pkg::ECS_FRST_CNT;
          end
        end
        ecs_pkg::ST_FULL: begin
          if (rstCntQ == 5'h0) begin
            stateQ <= ecs_pkg::ST_DONE;
          end else begin
            rstCntQ <= rstCntQ - 5'h1;
          end
        end
        ecs_pkg::ST_DONE: begin
          stateQ <= ecs_pkg::ST_IDLE;
        end
        default: begin
          stateQ <= ecs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // command register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmdQ <= ecs_pkg::ecs_cmd_type'(ecs_pkg::ECS_CMD_RST[7:0]);
    end else if (stateQ == ecs_pkg::ST_FULL) begin
      cmdQ           <= ecs_pkg::ecs_cmd_type'(ecs_pkg::ECS_CMD_RST[7:0]);
      cmdQ.fullReset <= (rstCntQ != 5'h0);
    end else if (lightFall) begin
      cmdQ <= ecs_pkg::ecs_cmd_type'(ecs_pkg::ECS_CMD_RST[7:0]);
    end else if (wrCmd) begin
      cmdQ      <= wrCmdVal;
      cmdQ.rsvd <= 3'h0;
    end
  end

  // ==========================================================
  // status and enables
  always_ff @(posedge core_clk) begin
    if (!rst_n || busy || lightFall) begin
      stsQ <= ecs_pkg::ecs_evt_type'(2'h0);
    end else begin
      stsQ.frame_list_rollover <= (stsQ.frame_list_rollover && !clrEvt.frame_list_rollover) || setEvt.frame_list_rollover;
      stsQ.port_change_detected <= (stsQ.port_change_detected && !clrEvt.port_change_detected) || setEvt.port_change_detected;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || busy || lightFall) begin
      ienQ <= ecs_pkg::ecs_evt_type'(2'h0);
    end else if (wrIen) begin
      ienQ <= wrEvt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lightQ <= 1'b0;
    end else begin
      lightQ <= lightFall;
    end
  end

  // ==========================================================
  // read port
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdDataQ  <= 32'h0000_0000;
      rdValidQ <= 1'b0;
    end else begin
      rdValidQ <= regRdEn;
      rdDataQ  <= 32'h0000_0000;
      if (regRdEn) begin
        unique case (regAddr)
          ecs_pkg::ECS_CMD_OFS: rdDataQ <= {24'h00_0000, cmdQ};
          ecs_pkg::ECS_STS_OFS: rdDataQ <= {28'h000_0000, stsQ, 2'h0};
          ecs_pkg::ECS_IEN_OFS: rdDataQ <= {28'h000_0000, ienQ, 2'h0};
          default:              rdDataQ <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // outputs
  assign regRdData       = rdValidQ ? rdDataQ : 32'h0000_0000;
  assign runSchedule     = cmdQ.runStop;
  assign frameListSize   = cmdQ.frame_list_size;
  assign hostResetActive = busy;
  assign lightResetPulse = lightQ;
  assign hostIrq = (stsQ.frame_list_rollover && ienQ.frame_list_rollover) || (stsQ.port_change_detected && ienQ.port_change_detected);

  always_comb begin
    unique case (cmdQ.frame_list_size)
      ecs_pkg::ECS_FLS_512: frameListEntries = ecs_pkg::ECS_LEN_512;
      ecs_pkg::ECS_FLS_256: frameListEntries = ecs_pkg::ECS_LEN_256;
      default:              frameListEntries = ecs_pkg::ECS_LEN_1024;
    endcase
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_fullStart;
    wrCmd && wrCmdVal.fullReset;
  endsequence

  sequence s_lightArm;
    wrCmd && wrCmdVal.lightReset;
  endsequence

  sequence s_lightDrop;
    wrCmd && !wrCmdVal.lightReset;
  endsequence

  AST_CMD_WRITE: assert property (
    wrCmd && !wrCmdVal.fullReset && !lightFall
    |=> runSchedule == $past(regWrData[ecs_pkg::ECS_RUN_BIT]))
    else $error("command write not applied");

  AST_LIGHT_RST: assert property (
    s_lightArm ##1 s_lightDrop |=> lightResetPulse && !runSchedule)
    else $error("light reset not performed");

  AST_FLS_FIELD: assert property (
    wrCmd && !lightFall && !wrCmdVal.fullReset
    |=> frameListSize == $past(regWrData[3:2]))
    else $error("frame list size not stored");

  AST_FULL_CLEARS: assert property (
    s_fullStart |=> hostResetActive ##[1:20] !cmdQ.fullReset && !hostResetActive)
    else $error("full reset bit did not clear");

  // busy for the full count plus the closing state
  AST_FULL_LEN: assert property (
    s_fullStart |-> ##17 hostResetActive ##1 !hostResetActive)
    else $error("full reset length wrong");

  AST_RUN_FOLLOWS: assert property (
    !wrCmd && !lightFall && !busy |=> $stable(runSchedule))
    else $error("run state changed without command write");

  AST_W1C_ZERO: assert property (
    stsQ.frame_list_rollover && wrSts && !regWrData[ecs_pkg::ECS_FLR_BIT] |=> stsQ.frame_list_rollover)
    else $error("status flag cleared by zero write");

  AST_W1C_ONE: assert property (
    wrSts && regWrData[ecs_pkg::ECS_FLR_BIT] && !setEvt.frame_list_rollover |=> !stsQ.frame_list_rollover)
    else $error("status flag not cleared by one write");

  AST_STS_ONLY: assert property (
    rdValidQ && $past(regAddr) == ecs_pkg::ECS_STS_OFS
    |-> regRdData[31:4] == 28'h000_0000 && regRdData[1:0] == 2'h0)
    else $error("status shows extra bits");

  AST_WRAP_SET: assert property (
    wrapBit != wrapBitPrev && !busy && !lightFall |=> stsQ.frame_list_rollover)
    else $error("rollover not flagged");

  AST_PORT_SET: assert property (
    |portRise && !busy && !lightFall |=> stsQ.port_change_detected)
    else $error("port change not flagged");

  AST_IRQ_FLR: assert property (
    stsQ.frame_list_rollover && ienQ.frame_list_rollover |-> hostIrq)
    else $error("rollover interrupt missing");

  AST_IRQ_PCD: assert property (
    hostIrq && !(stsQ.frame_list_rollover && ienQ.frame_list_rollover) |-> stsQ.port_change_detected && ienQ.port_change_detected)
    else $error("interrupt without enabled cause");

  AST_FLS_LEN: assert property (
    frameListSize == ecs_pkg::ECS_FLS_256 |-> frameListEntries == ecs_pkg::ECS_LEN_256)
    else $error("frame list length wrong");

endmodule : ecs_cmd_status

// ===== tb_top.sv
// Self-checking bench for the host command/status register pair.
// Assumes default port parameters (one port, three change bits) and one core clock.
`timescale 1ns/1ps
module tb_top;
  // ==========================================================
  // stimulus and observed signals
  logic        core_clk         = 1'b0;
  logic        rst_n            = 1'b0;
  logic [7:0]  regAddr          = 8'h00;
  logic [31:0] regWrData        = 32'h0000_0000;
  logic        regWrEn          = 1'b0;
  logic        regRdEn          = 1'b0;
  logic [13:0] frameIndex       = 14'h0000;
  logic [2:0]  portChangeBits   = 3'h0;
  logic        ownerRelease     = 1'b0;
  logic        resumeForce      = 1'b0;
  logic [31:0] regRdData;
  logic        runSchedule;
  logic [1:0]  frameListSize;
  logic [10:0] frameListEntries;
  logic        hostResetActive;
  logic        lightResetPulse;
  logic        hostIrq;
  int          miscompares      = 0;
  int          comparisons      = 0;
  int          resetCycles      = 0;
  logic [7:0]  cmdOfs           = ecs_pkg::ECS_CMD_OFS;
  logic [7:0]  stsOfs           = ecs_pkg::ECS_STS_OFS;
  logic [7:0]  ienOfs           = ecs_pkg::ECS_IEN_OFS;
  logic [7:0]  clrOfs           = ecs_pkg::ECS_CLR_OFS;
  logic [31:0] lens [4]         = '{32'h0000_0400, 32'h0000_0200, 32'h0000_0100,
                                    32'h0000_0400};

  always #12.5 core_clk = ~core_clk;

  ecs_cmd_status ecs_cmd_status_inst (
    .core_clk         (core_clk),
    .rst_n            (rst_n),
    .regAddr          (regAddr),
    .regWrData        (regWrData),
    .regWrEn          (regWrEn),
    .regRdEn          (regRdEn),
    .regRdData        (regRdData),
    .frameIndex       (frameIndex),
    .portChangeBits   (portChangeBits),
    .ownerRelease     (ownerRelease),
    .resumeForce      (resumeForce),
    .runSchedule      (runSchedule),
    .frameListSize    (frameListSize),
    .frameListEntries (frameListEntries),
    .hostResetActive  (hostResetActive),
    .lightResetPulse  (lightResetPulse),
    .hostIrq          (hostIrq)
  );

  always @(posedge core_clk) begin
    if (hostResetActive === 1'b1) begin
      resetCycles <= resetCycles + 1;
    end
  end

  // ==========================================================
  // access tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge core_clk);
    regWrEn   <= 1'b1;
    regAddr   <= addr;
    regWrData <= data;
    @(posedge core_clk);
    regWrEn <= 1'b0;
    #1;
  endtask : wr

  task automatic rdChk(input string what, input logic [7:0] addr, input logic [31:0] exp);
    @(posedge core_clk);
    regRdEn <= 1'b1;
    regAddr <= addr;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1;
    chk(what, exp, regRdData);
  endtask : rdChk

  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  initial begin
    #(25 * 4000);
    miscompares++;
    $display("watchdog expired");
    conclude();
  end

  // ==========================================================
  // tests
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    rdChk("command reset", cmdOfs, 32'h0000_0000);
    rdChk("status reset", stsOfs, 32'h0000_0000);
    rdChk("enable reset", ienOfs, 32'h0000_0000);
    chk("entries reset", 32'h0000_0400, 32'(frameListEntries));
    $display("test reset values done");

    for (int s = 0; s < 4; s++) begin
      wr(cmdOfs, 32'(s << 2) | 32'h0000_0001);
      chk("run", 32'h0000_0001, 32'(runSchedule));
      chk("size", 32'(s), 32'(frameListSize));
      chk("entries", lens[s], 32'(frameListEntries));
      rdChk("command", cmdOfs, 32'(s << 2) | 32'h0000_0001);
    end
    wr(cmdOfs, 32'h0000_0000);
    chk("stopped", 32'h0000_0000, 32'(runSchedule));
    rdChk("unmapped", 8'h40, 32'h0000_0000);
    rdChk("clear reads", clrOfs, 32'h0000_0000);
    $display("test command fields done");

    wr(ienOfs, 32'h0000_0008);
    for (int s = 0; s < 3; s++) begin
      wr(cmdOfs, 32'(s << 2));
      @(posedge core_clk);
      frameIndex <= frameIndex ^ 14'h0400;
      rdChk("no wrap", stsOfs, 32'h0000_0000);
      @(posedge core_clk);
      frameIndex <= frameIndex ^ (14'h2000 >> s);
      rdChk("wrap", stsOfs, 32'h0000_0008);
      chk("rollover irq", 32'h0000_0001, 32'(hostIrq));
      wr(stsOfs, 32'h0000_0000);
      rdChk("zero write", stsOfs, 32'h0000_0008);
      wr(stsOfs, 32'h0000_0008);
      rdChk("one write", stsOfs, 32'h0000_0000);
      chk("rollover ack", 32'h0000_0000, 32'(hostIrq));
    end
    $display("test rollover done");

    wr(ienOfs, 32'h0000_0004);
    @(posedge core_clk);
    ownerRelease   <= 1'b1;
    portChangeBits <= 3'h2;
    rdChk("released port", stsOfs, 32'h0000_0000);
    @(posedge core_clk);
    ownerRelease   <= 1'b0;
    portChangeBits <= 3'h6;
    rdChk("port change", stsOfs, 32'h0000_0004);
    chk("port irq", 32'h0000_0001, 32'(hostIrq));
    wr(clrOfs, 32'h0000_0004);
    rdChk("port clear", stsOfs, 32'h0000_0000);
    chk("port ack", 32'h0000_0000, 32'(hostIrq));
    @(posedge core_clk);
    resumeForce <= 1'b1;
    rdChk("resume", stsOfs, 32'h0000_0004);
    wr(stsOfs, 32'h0000_0004);
    $display("test port change done");

    wr(ienOfs, 32'h0000_000C);
    rdChk("enables set", ienOfs, 32'h0000_000C);
    wr(cmdOfs, 32'h0000_0005);
    wr(cmdOfs, 32'h0000_0085);
    wr(cmdOfs, 32'h0000_0000);
    chk("light pulse", 32'h0000_0001, 32'(lightResetPulse));
    @(posedge core_clk);
    #1;
    chk("light pulse end", 32'h0000_0000, 32'(lightResetPulse));
    rdChk("light command", cmdOfs, 32'h0000_0000);
    rdChk("light enables", ienOfs, 32'h0000_0000);
    $display("test light reset done");

    wr(cmdOfs, 32'h0000_0001);
    wr(ienOfs, 32'h0000_000C);
    // first full reset of the run, so the busy count starts from zero
    wr(cmdOfs, 32'h0000_0002);
    chk("reset active", 32'h0000_0001, 32'(hostResetActive));
    wr(ienOfs, 32'h0000_000C);
    rdChk("command in reset", cmdOfs, 32'h0000_0002);
    for (int i = 0; i < 40 && hostResetActive !== 1'b0; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk("reset length", 32'(ecs_pkg::ECS_FRST_CYC + 1), 32'(resetCycles));
    rdChk("command after", cmdOfs, 32'h0000_0000);
    rdChk("enables after", ienOfs, 32'h0000_0000);
    chk("run after", 32'h0000_0000, 32'(runSchedule));
    $display("test full reset done");
    conclude();
  end
endmodule : tb_top
